// file: src/ssp_baud_gen.sv
// 16-bit baud-rate generator giving one-cycle half-period enable pulses
`timescale 1ns/1ps
module ssp_baud_gen
  import ssp_pkg::*;
#(
  parameter int BAUD_W = SSP_BAUD_W
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // control
  input  wire logic              run,
  input  wire logic [BAUD_W-1:0] reload,
  // half-period tick
  output logic                   tick
);

  logic [BAUD_W-1:0] count_reg;

  // count down from the reload value, pulse on reaching zero
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      count_reg <= reload;
    end else if (count_reg == '0) begin
      count_reg <= reload;
    end else begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign tick = run && (count_reg == '0);

endmodule : ssp_baud_gen

// file: src/ssp_core.sv
// synchronous serial port: master/slave shift engine with buffers and flags
// Summary of operation
// - master makes the shift clock from a 16-bit baud-rate generator
// - slave takes its shift clock from the external master for every bit
// - full-duplex transfers in both modes; half-duplex in slave mode only
// - word width programmable from two to eight bits
// - software picks LSB-first or MSB-first shifting
// - shift clock idle level programmable low or high
// - data shifted on leading or trailing clock edge, programmable
// - request raised when transmit buffer empties and can take a word
// - request raised when a received word lands in the receive buffer
// - receive, phase, baud and transmit errors raise an error request
// - transmit and receive both double-buffered apart from the shifter
// - in master mode transmit goes to master-out pin, receive from master-in pin
// - master clock out and slave clock in share one shift-clock pin
`timescale 1ns/1ps
module ssp_core
  import ssp_pkg::*;
#(
  parameter int DATA_W = SSP_DATA_W,
  parameter int BAUD_W = SSP_BAUD_W
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // configuration
  input  wire logic              enable,
  input  wire logic              master_mode,
  input  wire logic              half_duplex,
  input  wire logic [2:0]        bits_minus_one,
  input  wire logic              lsb_first,
  input  wire logic              clk_idle_high,
  input  wire logic              shift_on_trail,
  input  wire logic [BAUD_W-1:0] baud_reload,
  // transmit buffer write
  input  wire logic              tx_write,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   tx_ready,
  // receive buffer read
  input  wire logic              rx_read,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   rx_valid,
  // status and requests
  input  wire logic [3:0]        err_clear,
  output logic [3:0]             err_flags,
  output logic                   busy,
  output logic                   tx_empty_req,
  output logic                   rx_full_req,
  output logic                   err_req,
  // serial pins
  output logic                   master_out_slave_in_pin_o,
  output logic                   master_out_slave_in_pin_oe,
  input  wire logic              master_out_slave_in_pin_i,
  output logic                   master_in_slave_out_pin_o,
  output logic                   master_in_slave_out_pin_oe,
  input  wire logic              master_in_slave_out_pin_i,
  output logic                   master_shift_clock_out,
  output logic                   shift_clock_pin_oe,
  input  wire logic              shift_clock_pin_i
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       sclk_prev_reg;
  logic       mosi_prev_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= {clk_idle_high, 2'h0};
      sync2_reg <= {clk_idle_high, 2'h0};
    end else begin
      sync1_reg <= {shift_clock_pin_i, master_out_slave_in_pin_i, master_in_slave_out_pin_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire logic sclk_s   = sync2_reg[2];
  wire logic mosi_s   = sync2_reg[1];
  wire logic miso_s   = sync2_reg[0];
  // receive line: slave reads master-out, master reads master-in
  wire logic rx_bit   = master_mode ? miso_s : mosi_s;

  // ****************************************
  // baud generator
  // ****************************************
  ssp_state_t state_reg;
  logic       tick;
  logic       clk_level_reg;
  logic [2:0] bit_cnt_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic [DATA_W-1:0] rx_shift_reg;
  logic [DATA_W-1:0] tx_buf_reg;
  logic       tx_full_reg;
  logic       out_bit_reg;

  ssp_baud_gen #(.BAUD_W(BAUD_W)) u_baud (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (enable && master_mode && state_reg != SSP_IDLE),
    .reload   (baud_reload),
    .tick     (tick)
  );

  // ****************************************
  // shift clock edges
  // ****************************************
  // slave edges come from the synchronised shared pin
  wire logic s_edge     = enable && !master_mode && (sclk_s != sclk_prev_reg);
  wire logic edge_ev    = master_mode ? tick : s_edge;
  // leading edge leaves idle level, trailing edge returns to it
  wire logic is_lead    = master_mode ? (clk_level_reg == clk_idle_high)
                                      : (sclk_s != clk_idle_high);
  wire logic sample_ev  = edge_ev && (is_lead != shift_on_trail);
  wire logic shift_ev   = edge_ev && (is_lead == shift_on_trail);
  wire logic last_bit   = (bit_cnt_reg == bits_minus_one);
  wire logic start      = enable && tx_full_reg && state_reg == SSP_IDLE;

  function automatic logic pick_bit(input logic [DATA_W-1:0] w, input logic lsb,
                                    input logic [2:0] msb_idx);
    pick_bit = lsb ? w[0] : w[msb_idx];
  endfunction : pick_bit

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_reg <= clk_idle_high;
      mosi_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      mosi_prev_reg <= mosi_s;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  // a word is complete at its last sample; the frame closes on the last bit's trailing edge, which is that sample itself when sampling on trailing edges
  logic word_done;
  logic tail_reg;
  logic frame_end;
  assign word_done = (state_reg != SSP_IDLE) && last_bit && sample_ev;
  assign frame_end = (state_reg == SSP_TRAIL) && edge_ev && (word_done || tail_reg);

  always_ff @(posedge core_clk) begin
    if (rst || !enable || start || frame_end) begin
      tail_reg <= 1'b0;
    end else if (word_done) begin
      tail_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || !enable) begin
      state_reg <= SSP_IDLE;
    end else begin
      case (state_reg)
        SSP_IDLE:  if (start) state_reg <= SSP_LEAD;
        SSP_LEAD:  if (edge_ev) state_reg <= SSP_TRAIL;
        SSP_TRAIL: begin
          if (frame_end && !tx_full_reg) begin
            state_reg <= SSP_IDLE;
          end else if (edge_ev) begin
            state_reg <= SSP_LEAD;
          end
        end
        default:   state_reg <= SSP_IDLE;
      endcase
    end
  end

  // master clock level toggles each half period, idles at polarity
  always_ff @(posedge core_clk) begin
    if (rst || state_reg == SSP_IDLE) begin
      clk_level_reg <= clk_idle_high;
    end else if (master_mode && tick) begin
      clk_level_reg <= ~clk_level_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || start) begin
      bit_cnt_reg <= 3'h0;
    end else if (sample_ev) begin
      bit_cnt_reg <= last_bit ? 3'h0 : bit_cnt_reg + 1'b1;
    end
  end

  // ****************************************
  // shift registers and buffers
  // ****************************************
  logic load_shift;
  assign load_shift = start || (frame_end && tx_full_reg);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_shift_reg <= SSP_DATA_RST;
      out_bit_reg  <= 1'b0;
    end else if (load_shift) begin
      tx_shift_reg <= tx_buf_reg;
      out_bit_reg  <= pick_bit(tx_buf_reg, lsb_first, bits_minus_one);
    // first bit already stands on the line before the first leading edge
    end else if (shift_ev && !(shift_on_trail && is_lead && bit_cnt_reg == 3'h0)) begin
      tx_shift_reg <= lsb_first ? (tx_shift_reg >> 1) : (tx_shift_reg << 1);
      out_bit_reg  <= lsb_first ? tx_shift_reg[1]
                                : tx_shift_reg[(bits_minus_one - 3'h1)];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || start) begin
      rx_shift_reg <= SSP_DATA_RST;
    end else if (sample_ev) begin
      rx_shift_reg <= lsb_first ? {rx_bit, rx_shift_reg[DATA_W-1:1]}
                                : {rx_shift_reg[DATA_W-2:0], rx_bit};
    end
  end

  // align an LSB-first word to bit zero for the programmed width
  logic [DATA_W-1:0] rx_word;
  always_comb begin
    rx_word = lsb_first ? {rx_bit, rx_shift_reg[DATA_W-1:1]}
                        : {rx_shift_reg[DATA_W-2:0], rx_bit};
    if (lsb_first) begin
      rx_word = rx_word >> (3'h7 - bits_minus_one);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_buf_reg  <= SSP_DATA_RST;
      tx_full_reg <= 1'b0;
    end else if (tx_write && !tx_full_reg) begin
      tx_buf_reg  <= tx_data;
      tx_full_reg <= 1'b1;
    end else if (load_shift) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_data  <= SSP_DATA_RST;
      rx_valid <= 1'b0;
    end else if (word_done) begin
      rx_data  <= rx_word;
      rx_valid <= 1'b1;
    end else if (rx_read) begin
      rx_valid <= 1'b0;
    end
  end

  // ****************************************
  // requests and error flags
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_empty_req <= 1'b0;
      rx_full_req  <= 1'b0;
    end else begin
      tx_empty_req <= load_shift;
      rx_full_req  <= word_done;
    end
  end

  logic [3:0] err_set;
  always_comb begin
    err_set                = 4'h0;
    err_set[SSP_ERR_RX]    = word_done && rx_valid && !rx_read;
    err_set[SSP_ERR_PHASE] = !master_mode && sample_ev && state_reg != SSP_IDLE &&
                             (mosi_s != mosi_prev_reg);
    err_set[SSP_ERR_BAUD]  = enable && master_mode && start && baud_reload == '0;
    err_set[SSP_ERR_TX]    = !master_mode && s_edge && state_reg == SSP_IDLE &&
                             !tx_full_reg;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_flags <= 4'h0;
    end else begin
      err_flags <= (err_flags & ~err_clear) | err_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_req <= 1'b0;
    end else begin
      err_req <= |err_set;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  assign tx_ready = !tx_full_reg;
  assign busy     = state_reg != SSP_IDLE;
  assign master_shift_clock_out     = master_mode ? clk_level_reg : clk_idle_high;
  assign shift_clock_pin_oe         = enable && master_mode;
  // slave half duplex: both ends talk on master-out; full duplex and master mode use both lines
  assign master_out_slave_in_pin_o  = out_bit_reg;
  assign master_out_slave_in_pin_oe = enable && (master_mode || (half_duplex && busy));
  assign master_in_slave_out_pin_o  = out_bit_reg;
  assign master_in_slave_out_pin_oe = enable && !master_mode && !half_duplex && busy;

endmodule : ssp_core

// file: src/ssp_pkg.sv
// constants and types shared by the synchronous serial port
package ssp_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int          SSP_BAUD_W      = 16;
  localparam int          SSP_DATA_W      = 8;
  localparam int          SSP_BITS_W      = 3;
  localparam logic [15:0] SSP_BAUD_RST    = 16'h0001;
  localparam logic [2:0]  SSP_BITS_MIN    = 3'h1;
  localparam logic [7:0]  SSP_DATA_RST    = 8'h00;

  // ****************************************
  // error flag positions
  // ****************************************
  localparam int          SSP_ERR_RX      = 0;
  localparam int          SSP_ERR_PHASE   = 1;
  localparam int          SSP_ERR_BAUD    = 2;
  localparam int          SSP_ERR_TX      = 3;
  localparam int          SSP_ERR_N       = 4;

  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_LEAD,
    SSP_TRAIL
  } ssp_state_t;

endpackage : ssp_pkg

// file: verif/ssp_core_checker.sv
// concurrent checks on the serial port core ports
`timescale 1ns/1ps
module ssp_core_checker
  import ssp_pkg::*;
#(
  parameter int DATA_W = SSP_DATA_W,
  parameter int BAUD_W = SSP_BAUD_W
) (
  // clock, reset and settings
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              enable,
  input wire logic              master_mode,
  input wire logic              clk_idle_high,
  input wire logic [BAUD_W-1:0] baud_reload,
  // buffers, status and requests
  input wire logic              tx_write,
  input wire logic              tx_ready,
  input wire logic              rx_valid,
  input wire logic [3:0]        err_clear,
  input wire logic [3:0]        err_flags,
  input wire logic              busy,
  input wire logic              tx_empty_req,
  input wire logic              rx_full_req,
  input wire logic              err_req,
  // pins
  input wire logic              master_out_slave_in_pin_oe,
  input wire logic              master_shift_clock_out,
  input wire logic              shift_clock_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // half period measurement
  // ****************************************
  logic              clk_prev;
  logic              gap_seen;
  logic [BAUD_W-1:0] gap_cnt;
  wire               toggle = master_shift_clock_out != clk_prev;
  always_ff @(posedge core_clk) clk_prev <= master_shift_clock_out;
  always_ff @(posedge core_clk) gap_cnt <= toggle ? '0 : gap_cnt + 1'b1;
  always_ff @(posedge core_clk) gap_seen <= !rst && busy && master_mode && (gap_seen || toggle);
  sequence word_taken;
    tx_write && tx_ready && !busy && master_mode && enable && baud_reload != 16'h0000;
  endsequence
  sequence clk_toggle;
    toggle;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_half_period: assert property ((busy && gap_seen) ##0 clk_toggle |->
    gap_cnt == baud_reload)
    else $error("shift clock half period wrong");
  chk_start_busy: assert property (word_taken |=> ##1 busy)
    else $error("accepted word did not start");
  chk_idle_level: assert property (master_mode && !busy && !$past(busy) && $stable(clk_idle_high)
    |-> master_shift_clock_out == clk_idle_high)
    else $error("shift clock not at idle level");
  chk_rx_full: assert property (rx_full_req |-> ##[0:1] rx_valid ##1 !rx_full_req)
    else $error("receive request without valid word");
  chk_tx_empty: assert property (tx_empty_req |-> tx_ready ##1 !tx_empty_req)
    else $error("empty request while buffer full");
  chk_err_req: assert property (err_req |-> ##[0:1] (err_flags != 4'h0))
    else $error("error request without flag");
  chk_err_sticky: assert property (1'b1 |=> (err_flags & $past(err_flags & ~err_clear))
    == $past(err_flags & ~err_clear))
    else $error("error flag dropped without clear");
  chk_clk_pin_oe: assert property (enable |-> shift_clock_pin_oe == master_mode)
    else $error("shift clock pin direction wrong");
  chk_out_pin_oe: assert property (enable && master_mode |-> master_out_slave_in_pin_oe)
    else $error("master out line not driven");
  chk_reset_clean: assert property ($fell(rst) |-> err_flags == 4'h0 && !rx_valid)
    else $error("flags not clear after reset");
endmodule : ssp_core_checker
bind ssp_core ssp_core_checker #(.DATA_W(DATA_W), .BAUD_W(BAUD_W)) ssp_core_checker_i (.*);

// file: verif/ssp_far_dev.sv
// far-side device: captures the outgoing line, answers with its inverse
`timescale 1ns/1ps
module ssp_far_dev (
  // shift clock and settings
  input  wire logic       sclk,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       clr,
  // data lines
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      cap
);
  assign miso = ~mosi;
  // takes its clock from the master and samples on the agreed edge
  always @(sclk or posedge clr) begin
    if (clr)
      cap = 8'h00;
    else if ((sclk ^ cpol) !== cpha)
      #1 cap = {cap[6:0], mosi};
  end
endmodule : ssp_far_dev

// file: verif/tb.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
module tb;
  import ssp_pkg::*;
  logic        core_clk, rst, enable, master_mode, half_duplex, lsb_first, clk_idle_high;
  logic        shift_on_trail, tx_write, rx_read, tb_mosi, tb_sclk, clr, far_miso;
  logic        tx_ready, rx_valid, busy, tx_empty_req, rx_full_req, err_req;
  logic        master_out_slave_in_pin_o, master_out_slave_in_pin_oe, master_in_slave_out_pin_o;
  logic        master_in_slave_out_pin_oe, master_shift_clock_out, shift_clock_pin_oe;
  logic [2:0]  bits_minus_one;
  logic [15:0] baud_reload;
  logic [7:0]  tx_data, rx_data, far_cap, q;
  logic [3:0]  err_clear, err_flags;
  wire         master_out_slave_in_pin_i, master_in_slave_out_pin_i, shift_clock_pin_i;
  int          n_errors = 0, total_checks = 0, n_edges, n_txe, n_rxf, n_erq, k;
  // each pin carries whichever party enables its driver
  assign master_out_slave_in_pin_i = master_out_slave_in_pin_oe ? master_out_slave_in_pin_o
                                                                : tb_mosi;
  assign master_in_slave_out_pin_i = master_in_slave_out_pin_oe ? master_in_slave_out_pin_o
                                                                : far_miso;
  assign shift_clock_pin_i = shift_clock_pin_oe ? master_shift_clock_out : tb_sclk;
  ssp_core ssp_core_i (.*);
  ssp_far_dev ssp_far_dev_i (.sclk(shift_clock_pin_i), .cpol(clk_idle_high),
    .cpha(shift_on_trail), .clr(clr), .mosi(master_out_slave_in_pin_i), .miso(far_miso),
    .cap(far_cap));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(master_shift_clock_out) n_edges++;
  always @(posedge core_clk) begin
    n_txe += int'(tx_empty_req === 1'b1);
    n_rxf += int'(rx_full_req === 1'b1);
    n_erq += int'(err_req === 1'b1);
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic xfer(input int n, input logic [2:0] md, input logic [7:0] d);
    logic [7:0] m, r;
    m = 8'hFF >> (8 - n);
    for (int j = 0; j < 8; j++) r[j] = (j < n) ? d[n-1-j] : 1'b0;
    bits_minus_one = 3'(n - 1);
    {lsb_first, shift_on_trail, clk_idle_high} = md;
    baud_reload = 16'(n + 1);
    repeat (3) @(negedge core_clk);
    chk(master_shift_clock_out, clk_idle_high);
    chk(tx_ready, 1'b1);
    {clr, tx_write, tx_data} = {2'b11, d};
    {n_edges, n_txe, n_rxf} = {32'h0, 32'h0, 32'h0};
    @(negedge core_clk);
    {clr, tx_write} = 2'b00;
    for (k = 0; k < 3000 && !(n_rxf > 0 && busy === 1'b0); k++) @(negedge core_clk);
    if (k == 3000) begin
      n_errors++;
      wrap_up;
    end
    chk(rx_data & m, ~d & m);
    chk(far_cap & m, lsb_first ? r : d & m);
    chk(n_edges, 2 * n);
    chk(n_txe, 1);
    chk(n_rxf, 1);
    rx_read = 1'b1;
    @(negedge core_clk);
    rx_read = 1'b0;
    chk(rx_valid, 1'b0);
  endtask : xfer
  // clock one word into the port as an outside master and gather its answer
  task automatic slave_word(input logic [7:0] d, output logic [7:0] a);
    for (int j = 7; j >= 0; j--) begin
      tb_mosi = d[j];
      repeat (6) @(negedge core_clk);
      a[j] = master_in_slave_out_pin_i;
      tb_sclk = 1'b1;
      repeat (6) @(negedge core_clk);
      tb_sclk = 1'b0;
    end
    tb_mosi = ~tb_mosi;
    repeat (6) @(negedge core_clk);
  endtask : slave_word
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst, enable, master_mode, half_duplex, tx_write, rx_read, clr} = 7'h70;
    {lsb_first, clk_idle_high, shift_on_trail, tb_mosi, tb_sclk} = 5'h02;
    {bits_minus_one, baud_reload, tx_data, err_clear} = {3'h7, 16'h0003, 8'h00, 4'h0};
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk({err_flags, rx_valid, busy, tx_ready}, 16'h0001);
    for (int i = 0; i < 7; i++) xfer(i + 2, 3'(i), 8'h96 + 8'(i * 29));
    {master_mode, bits_minus_one, lsb_first, clk_idle_high, shift_on_trail} = 7'h38;
    {tx_write, tx_data} = {1'b1, 8'h3C};
    @(negedge core_clk);
    tx_write = 1'b0;
    n_rxf = 0;
    slave_word(8'hC5, q);
    chk(q, 8'h3C);
    chk(rx_data, 8'hC5);
    chk(n_rxf, 1);
    n_erq = 0;
    {half_duplex, tx_write, tx_data} = {2'b11, 8'hA5};
    @(negedge core_clk);
    tx_write = 1'b0;
    slave_word(8'h00, q);
    chk(q, 8'h5A);
    chk(rx_data, 8'hA5);
    half_duplex = 1'b0;
    slave_word(8'h5A, q);
    chk(err_flags, 4'h9);
    chk(n_erq > 0, 1'b1);
    for (int i = 3; i >= 0; i -= 3) begin
      err_clear = 4'h1 << i;
      @(negedge core_clk);
      err_clear = 4'h0;
      @(negedge core_clk);
      chk(err_flags, (i == 3) ? 4'h1 : 4'h0);
    end
    {master_mode, baud_reload, tx_write} = {1'b1, 16'h0000, 1'b1};
    @(negedge core_clk);
    tx_write = 1'b0;
    for (k = 0; k < 50 && err_flags[2] !== 1'b1; k++) @(negedge core_clk);
    chk(err_flags[2], 1'b1);
    wrap_up;
  end
endmodule : tb
